/* crc_engine.sv */
// programmable crc engine: fifo, shifter, result and events
`include "crc_regs.svh"
module crc_engine (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // control one
  input  wire logic        module_enable_bit,
  input  wire logic        shift_direction_bit,
  input  wire logic        interrupt_select_bit,
  input  wire logic        go_set,
  input  wire logic        go_clear,
  // control two
  input  wire logic [4:0]  data_width_field,
  input  wire logic [4:0]  poly_length_field,
  // polynomial terms
  input  wire logic [15:0] poly_mask_low,
  input  wire logic [15:0] poly_mask_high,
  // data input, byte lane write strobes
  input  wire logic [15:0] data_input_low,
  input  wire logic [15:0] data_input_high,
  input  wire logic [1:0]  data_low_be,
  input  wire logic [1:0]  data_high_be,
  // result write port
  input  wire logic        result_low_wr,
  input  wire logic        result_high_wr,
  input  wire logic [15:0] result_wdata,
  // status
  output logic             go_bit,
  output logic      [4:0]  valid_word_count,
  output logic             fifo_full_flag,
  output logic             fifo_empty_flag,
  output logic      [15:0] result_low,
  output logic      [15:0] result_high,
  output logic             crc_event
);
  crc_fifo_if fifo_bus ();

  crc_pkg::crc_state_type state_reg;   // shifter state
  crc_pkg::crc_state_type state_next;
  logic [31:0] buf_reg;                // word being shifted
  logic [31:0] buf_next;
  logic [5:0]  rem_reg;                // bits left in word
  logic [5:0]  rem_next;
  logic [31:0] result_reg;             // engine contents
  logic [31:0] result_next;
  logic [31:0] stage_reg;              // partly written word
  logic [31:0] stage_next;
  logic        go_reg;                 // calculation running
  logic        go_next;
  logic        event_reg;              // event pulse
  logic        event_next;
  logic [31:0] merged;                 // stage plus new bytes
  logic [3:0]  lane_we;                // byte lanes written
  logic [4:0]  depth;                  // band depth
  logic        msb_written;            // word completed
  logic        push;                   // word accepted
  logic        load;                   // pop into buffer
  logic        last_step;              // final bits of word
  logic        auto_done;              // hardware go clear
  logic        bit_first;              // first data bit
  logic        bit_second;             // second data bit
  logic        two_bits;               // two bits remain
  logic [31:0] step_out;               // engine after step

  // depth for a width field value
  function automatic logic [4:0] fifo_depth(input logic [4:0] w);
    if (w >= `CRC_WIDE_MIN) begin
      return `CRC_DEPTH_WIDE;
    end else if (w >= `CRC_MID_MIN) begin
      return `CRC_DEPTH_MID;
    end
    return `CRC_DEPTH_NARROW;
  endfunction

  // mask of the bits inside a data word
  function automatic logic [31:0] width_mask(input logic [4:0] w);
    return 32'hFFFF_FFFF >> (5'h1F - w);
  endfunction

  crc_word_fifo #(
    .DEPTH (16)
  ) u_fifo (
    .ref_clk (ref_clk),
    .reset   (reset),
    .fifo    (fifo_bus.store)
  );

  crc_shift_step u_step (
    .crc_in            (result_reg),
    .poly_mask         ({poly_mask_high, poly_mask_low}),
    .poly_length_field (poly_length_field),
    .bit_first         (bit_first),
    .bit_second        (bit_second),
    .two_bits          (two_bits),
    .crc_out           (step_out)
  );

  // data input path: lanes merge into the staging word
  always_comb begin
    lane_we = {data_high_be, data_low_be};
    merged  = stage_reg;
    for (int i = 0; i < 2; i++) begin
      if (data_low_be[i]) begin
        merged[8*i +: 8] = data_input_low[8*i +: 8];
      end
      if (data_high_be[i]) begin
        merged[16 + 8*i +: 8] = data_input_high[8*i +: 8];
      end
    end
    // byte holding the width msb completes a word
    msb_written = lane_we[data_width_field[4:3]];
    depth       = fifo_depth(data_width_field);
    // a full fifo drops the word, count untouched
    push = module_enable_bit && msb_written
           && (fifo_bus.count < depth);
    stage_next = module_enable_bit ? merged : 32'h0000_0000;
  end

  // shifter: pick the data bits for this cycle
  always_comb begin
    if (shift_direction_bit) begin
      bit_first  = buf_reg[0];
      bit_second = buf_reg[1];
    end else begin
      bit_first  = buf_reg[31];
      bit_second = buf_reg[30];
    end
    two_bits  = rem_reg >= `CRC_BITS_PER_CYCLE;
    last_step = rem_reg <= `CRC_BITS_PER_CYCLE;
  end

  // shifter sequencing, go bit and event
  always_comb begin
    state_next  = state_reg;
    buf_next    = buf_reg;
    rem_next    = rem_reg;
    result_next = result_reg;
    load        = 1'b0;
    auto_done   = 1'b0;
    unique case (state_reg)
      crc_pkg::ST_IDLE: begin
        // start from whatever the result holds
        if (go_reg && fifo_bus.count != 5'h00) begin
          load = 1'b1;
        end
      end
      crc_pkg::ST_SHIFT: begin
        result_next = step_out;
        if (shift_direction_bit) begin
          buf_next = buf_reg >> 2;
        end else begin
          buf_next = buf_reg << 2;
        end
        rem_next = rem_reg - (two_bits ? 6'h02 : 6'h01);
        if (last_step) begin
          // reload back to back while words remain
          if (go_reg && fifo_bus.count != 5'h00) begin
            load = 1'b1;
          end else begin
            state_next = crc_pkg::ST_IDLE;
            auto_done  = go_reg;
          end
        end
      end
    endcase
    if (load) begin
      state_next = crc_pkg::ST_SHIFT;
      rem_next   = {1'b0, data_width_field} + 6'h01;
      // msb first: left align so the width msb sits at bit 31
      buf_next = shift_direction_bit
        ? (fifo_bus.pop_data & width_mask(data_width_field))
        : ((fifo_bus.pop_data & width_mask(data_width_field))
           << (5'h1F - data_width_field));
    end
    // software writes win over the engine step
    if (result_low_wr) begin
      result_next[15:0] = result_wdata;
    end
    if (result_high_wr) begin
      result_next[31:16] = result_wdata;
    end
    // software set beats the automatic clear
    go_next = go_reg;
    if (go_clear || auto_done) begin
      go_next = 1'b0;
    end
    if (go_set) begin
      go_next = 1'b1;
    end
    // event source per interrupt select
    if (interrupt_select_bit) begin
      event_next = auto_done && !go_set;
    end else begin
      event_next = (fifo_bus.count == 5'h01)
                   && load && !push;
    end
    // disabled: all sequencing state back to rest
    if (!module_enable_bit) begin
      state_next  = crc_pkg::ST_IDLE;
      buf_next    = 32'h0000_0000;
      rem_next    = 6'h00;
      result_next = `CRC_RESULT_RESET;
      load        = 1'b0;
      go_next     = `CRC_GO_RESET;
      event_next  = 1'b0;
    end
  end

  // fifo control through the carrier
  always_comb begin
    fifo_bus.clear     = !module_enable_bit;
    fifo_bus.push      = push;
    fifo_bus.push_data = merged;
    fifo_bus.pop       = load;
  end

  // register the sequencing and data state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg  <= crc_pkg::ST_IDLE;
      buf_reg    <= 32'h0000_0000;
      rem_reg    <= 6'h00;
      result_reg <= `CRC_RESULT_RESET;
      stage_reg  <= 32'h0000_0000;
      go_reg     <= `CRC_GO_RESET;
      event_reg  <= 1'b0;
    end else begin
      state_reg  <= state_next;
      buf_reg    <= buf_next;
      rem_reg    <= rem_next;
      result_reg <= result_next;
      stage_reg  <= stage_next;
      go_reg     <= go_next;
      event_reg  <= event_next;
    end
  end

  // status outputs; flags follow the registered count
  always_comb begin
    go_bit           = go_reg;
    valid_word_count = fifo_bus.count;
    fifo_full_flag   = fifo_bus.count == depth;
    fifo_empty_flag  = fifo_bus.count == 5'h00;
    result_low       = result_reg[15:0];
    result_high      = result_reg[31:16];
    crc_event        = event_reg;
  end

  // checks on the shifter, fifo count and events
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_disable_empties: assert property (
    !module_enable_bit |=> valid_word_count == 5'h00 && !go_bit)
    else $error("count not cleared while disabled");

  a_full_at_depth: assert property (
    (data_width_field == 5'h1F && valid_word_count == 5'h04)
    |-> fifo_full_flag)
    else $error("full flag missing at depth four");

  a_narrow_not_full: assert property (
    (data_width_field < 5'h08 && valid_word_count == 5'h08)
    |-> !fifo_full_flag)
    else $error("narrow width full at eight");

  a_full_write_dropped: assert property (
    (module_enable_bit && fifo_full_flag && msb_written && !load)
    |=> $stable(valid_word_count))
    else $error("write while full changed count");

  a_write_counts: assert property (
    (module_enable_bit && push && !load)
    |=> valid_word_count == $past(valid_word_count) + 5'h01)
    else $error("completed word not counted");

  a_word_sixteen: assert property (
    (load && module_enable_bit && data_width_field == 5'h1F)
    |=> rem_reg == 6'h20 ##15 (rem_reg == 6'h02 && last_step))
    else $error("32 bit word not sixteen cycles");

  a_auto_clear_event: assert property (
    (auto_done && interrupt_select_bit && module_enable_bit
     && !go_set)
    |=> crc_event && !go_bit)
    else $error("completion without event or go clear");

  a_manual_clear_quiet: assert property (
    (interrupt_select_bit && go_clear && !go_set
     && state_reg == crc_pkg::ST_IDLE)
    |=> !crc_event)
    else $error("software go clear raised event");

  a_count_event: assert property (
    (module_enable_bit && !interrupt_select_bit
     && valid_word_count == 5'h01 && load && !push)
    |=> crc_event && valid_word_count == 5'h00)
    else $error("no event on count one to zero");

  c_fifo_fills: cover property (
    module_enable_bit && fifo_full_flag);

  c_auto_complete: cover property (
    interrupt_select_bit ##0 auto_done ##1 crc_event);

  c_lsb_first_word: cover property (
    shift_direction_bit && load ##1 state_reg == crc_pkg::ST_SHIFT);

  c_back_to_back: cover property (
    state_reg == crc_pkg::ST_SHIFT && load);
endmodule

/* crc_regs.svh */
// constants for the programmable crc engine
`ifndef CRC_REGS_SVH
`define CRC_REGS_SVH
// fifo depth per data width band
`define CRC_DEPTH_WIDE      5'h04
`define CRC_DEPTH_MID       5'h08
`define CRC_DEPTH_NARROW    5'h10
// width field thresholds for the depth bands
`define CRC_WIDE_MIN        5'h10
`define CRC_MID_MIN         5'h08
// field values for the common polynomial lengths
`define CRC_POLY_LENGTH_FIELD_16         5'h0F
`define CRC_POLY_LENGTH_FIELD_32         5'h1F
// bits moved into the engine per clock
`define CRC_BITS_PER_CYCLE  6'h02
// reset values
`define CRC_COUNT_RESET     5'h00
`define CRC_RESULT_RESET    32'h0000_0000
`define CRC_GO_RESET        1'b0
`endif

/* crc_pkg.sv */
// shared types of the programmable crc engine
package crc_pkg;
  // shifter sequencing states
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } crc_state_type;
  // valid word count, 0 to 16
  typedef logic [4:0] crc_count_type;
endpackage

/* crc_fifo_if.sv */
// carrier between the crc core and its word fifo
interface crc_fifo_if;
  logic                   clear;     // empty the fifo
  logic                   push;      // store push_data
  logic [31:0]            push_data; // word to store
  logic                   pop;       // drop oldest word
  logic [31:0]            pop_data;  // oldest word
  crc_pkg::crc_count_type count;     // words held
  modport store (input clear, push, push_data, pop,
                 output pop_data, count);
  modport user  (output clear, push, push_data, pop,
                 input pop_data, count);
endinterface

/* crc_word_fifo.sv */
// sixteen word storage fifo behind the crc data input
`include "crc_regs.svh"
module crc_word_fifo #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // core side
  crc_fifo_if.store fifo
);
  logic [31:0]            mem [DEPTH];   // word storage
  logic [3:0]             wr_ptr_reg;    // next write slot
  logic [3:0]             wr_ptr_next;
  logic [3:0]             rd_ptr_reg;    // oldest slot
  logic [3:0]             rd_ptr_next;
  crc_pkg::crc_count_type count_reg;     // words held
  crc_pkg::crc_count_type count_next;

  // pointer and count update; clear beats push and pop
  always_comb begin
    wr_ptr_next = wr_ptr_reg + 4'(fifo.push);
    rd_ptr_next = rd_ptr_reg + 4'(fifo.pop);
    count_next  = count_reg + 5'(fifo.push) - 5'(fifo.pop);
    if (fifo.clear) begin
      wr_ptr_next = 4'h0;
      rd_ptr_next = 4'h0;
      count_next  = `CRC_COUNT_RESET;
    end
  end

  // register pointers and count
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      count_reg  <= `CRC_COUNT_RESET;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // storage write; contents need no reset
  always_ff @(posedge ref_clk) begin
    if (fifo.push && !fifo.clear) begin
      mem[wr_ptr_reg] <= fifo.push_data;
    end
  end

  assign fifo.pop_data = mem[rd_ptr_reg];
  assign fifo.count    = count_reg;
endmodule

/* crc_shift_step.sv */
// two bit step of the programmable crc shift engine
module crc_shift_step (
  // engine state and setup
  input  wire logic [31:0] crc_in,
  input  wire logic [31:0] poly_mask,
  input  wire logic [4:0]  poly_length_field,
  // data bits, first then second
  input  wire logic        bit_first,
  input  wire logic        bit_second,
  input  wire logic        two_bits,
  // next engine state
  output logic      [31:0] crc_out
);
  logic [31:0] len_mask;   // bits inside the polynomial
  logic [31:0] taps;       // active xor positions
  logic [31:0] mid;        // state after the first bit

  // one engine bit; the top term is implied by the feedback
  function automatic logic [31:0] crc_bit(
    input logic [31:0] c,
    input logic        d,
    input logic [31:0] t,
    input logic [31:0] m,
    input logic [4:0]  top
  );
    logic fb;
    fb = c[top] ^ d;
    return ((c << 1) & m) ^ (fb ? t : 32'h0000_0000);
  endfunction

  // term 0 always taps whatever the mask holds
  always_comb begin
    len_mask = 32'hFFFF_FFFF >> (5'h1F - poly_length_field);
    taps     = (poly_mask | 32'h0000_0001) & len_mask;
    mid      = crc_bit(crc_in, bit_first, taps, len_mask,
                       poly_length_field);
    crc_out  = two_bits ? crc_bit(mid, bit_second, taps, len_mask,
                                  poly_length_field) : mid;
  end
endmodule

/* tb.sv */
// self-checking bench for the programmable crc engine
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // control and data stimulus
  logic        ref_clk, reset, module_enable_bit, shift_direction_bit;
  logic        interrupt_select_bit, go_set, go_clear;
  logic        result_low_wr, result_high_wr;
  logic [4:0]  data_width_field, poly_length_field;
  logic [15:0] poly_mask_low, poly_mask_high, result_wdata;
  logic [15:0] data_input_low, data_input_high;
  logic [1:0]  data_low_be, data_high_be;
  // observed status
  logic        go_bit, fifo_full_flag, fifo_empty_flag, crc_event;
  logic [4:0]  valid_word_count;
  logic [15:0] result_low, result_high;
  // bookkeeping
  int          fail_count, total_checks, event_count, cyc, ev0;
  logic [31:0] words [4];

  crc_engine dut (.ref_clk, .reset, .module_enable_bit,
    .shift_direction_bit, .interrupt_select_bit, .go_set, .go_clear,
    .data_width_field, .poly_length_field, .poly_mask_low,
    .poly_mask_high, .data_input_low, .data_input_high, .data_low_be,
    .data_high_be, .result_low_wr, .result_high_wr, .result_wdata,
    .go_bit, .valid_word_count, .fifo_full_flag, .fifo_empty_flag,
    .result_low, .result_high, .crc_event);

  // 100 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // event pulses are one cycle, so count them at every edge
  always @(posedge ref_clk) begin
    if (crc_event === 1'b1) event_count++;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // bit serial reference; taps below the length, zero term forced
  function automatic logic [31:0] crc_ref(input logic [31:0] crc, mask,
      input logic [4:0] pf, wf, input logic lsb, input int first, last);
    logic        fb;
    logic [31:0] keep;
    int          n, wb;
    n = pf + 1;
    wb = wf + 1;
    keep = (n == 32) ? 32'hFFFF_FFFF : (32'h1 << n) - 32'h1;
    for (int k = first; k < last; k++) begin
      for (int i = 0; i < wb; i++) begin
        fb = crc[n - 1] ^ (lsb ? words[k][i] : words[k][wb - 1 - i]);
        crc = (crc << 1) ^ (fb ? (mask | 32'h1) : 32'h0);
      end
    end
    return crc & keep;
  endfunction

  // strobe every lane up to the msb lane; calls may run back to back
  task automatic put_word(input logic [31:0] w, input logic [4:0] wf);
    @(negedge ref_clk);
    data_input_low = w[15:0];
    data_input_high = w[31:16];
    data_low_be = (wf[4:3] == 2'h0) ? 2'h1 : 2'h3;
    data_high_be = (wf[4:3] == 2'h3) ? 2'h3 :
                   (wf[4:3] == 2'h2) ? 2'h1 : 2'h0;
  endtask

  task automatic idle_bus();
    @(negedge ref_clk);
    data_low_be = 2'h0;
    data_high_be = 2'h0;
  endtask

  // re-enable, configure, preload, seed the result
  task automatic setup(input logic [4:0] wf, pf, input logic [31:0] mask,
      input logic lsb, sel, input logic [31:0] start, input int nw);
    @(negedge ref_clk);
    module_enable_bit = 1'b0;
    @(negedge ref_clk);
    module_enable_bit = 1'b1;
    data_width_field = wf;
    poly_length_field = pf;
    {poly_mask_high, poly_mask_low} = mask;
    shift_direction_bit = lsb;
    interrupt_select_bit = sel;
    for (int i = 0; i < nw; i++) put_word(words[i], wf);
    idle_bus();
    result_wdata = start[15:0];
    result_low_wr = 1'b1;
    @(negedge ref_clk);
    result_low_wr = 1'b0;
    result_high_wr = 1'b1;
    result_wdata = start[31:16];
    @(negedge ref_clk);
    result_high_wr = 1'b0;
    ev0 = event_count;
  endtask

  // bounded wait for go to drop; counts cycles from the request
  task automatic wait_idle();
    for (cyc = 1; cyc <= 400; cyc++) begin
      @(negedge ref_clk);
      go_set = 1'b0;
      go_clear = 1'b0;
      if (go_bit === 1'b0) break;
    end
    if (cyc > 400) begin
      fail_count++;
      $display("unexpected go_bit expected 0 seen 1");
      complete_run();
    end
  endtask

  task automatic run_go();
    @(negedge ref_clk);
    go_set = 1'b1;
    wait_idle();
    // the completion pulse is only counted at the next rising edge
    @(negedge ref_clk);
  endtask

  task automatic test_reset();
    check("go", go_bit, 32'h0);
    check("count", valid_word_count, 32'h0);
    check("empty", fifo_empty_flag, 32'h1);
    check("full", fifo_full_flag, 32'h0);
    check("result", {result_high, result_low}, 32'h0);
    $display("reset test done");
  endtask

  // each width band: fill, overfill, disable; partial write in the wide and mid bands only
  task automatic test_depth();
    logic [4:0] wf [4];
    int         dep [4];
    wf = '{5'h10, 5'h0F, 5'h08, 5'h07};
    dep = '{4, 8, 8, 16};
    for (int k = 0; k < 4; k++) begin
      setup(wf[k], 5'h0F, 32'h0, 1'b0, 1'b0, 32'h0, 0);
      if (k < 3) begin
        @(negedge ref_clk);
        data_low_be = 2'h1;
        idle_bus();
        check("count", valid_word_count, 32'h0);
      end
      for (int i = 1; i < dep[k]; i++) put_word(32'hFFFF_FFFF, wf[k]);
      idle_bus();
      check("count", valid_word_count, dep[k] - 1);
      check("full", fifo_full_flag, 32'h0);
      check("empty", fifo_empty_flag, 32'h0);
      put_word(32'h1234_5678, wf[k]);
      put_word(32'h9ABC_DEF0, wf[k]);
      idle_bus();
      check("count", valid_word_count, dep[k]);
      check("full", fifo_full_flag, 32'h1);
      module_enable_bit = 1'b0;
      @(negedge ref_clk);
      check("count", valid_word_count, 32'h0);
      check("empty", fifo_empty_flag, 32'h1);
      module_enable_bit = 1'b1;
    end
    $display("depth test done");
  endtask

  // 16 bit polynomial, one 32 bit word, msb first, completion event
  task automatic test_msb();
    words[0] = 32'h1234_5678;
    setup(5'h1F, 5'h0F, 32'h0000_1021, 1'b0, 1'b1, 32'h0, 1);
    run_go();
    check("cycles", cyc, 18);
    check("result", {result_high, result_low},
          crc_ref(32'h0, 32'h1021, 5'h0F, 5'h1F, 1'b0, 0, 1));
    check("events", event_count - ev0, 1);
    check("empty", fifo_empty_flag, 32'h1);
    $display("msb test done");
  endtask

  // 32 bit polynomial, byte words with junk above, lsb first
  task automatic test_lsb();
    words = '{32'hFFFF_FF31, 32'h0000_00A7, 32'h1234_5600, 32'h0};
    setup(5'h07, 5'h1F, 32'h04C1_1DB6, 1'b1, 1'b0, 32'h0, 3);
    run_go();
    check("cycles", cyc, 14);
    check("result", {result_high, result_low},
          crc_ref(32'h0, 32'h04C1_1DB6, 5'h1F, 5'h07, 1'b1, 0, 3));
    check("events", event_count - ev0, 1);
    $display("lsb test done");
  endtask

  // 8 bit polynomial, six bit words, seeded result, zero term set
  task automatic test_seed();
    words[0] = 32'hFFFF_FFC5;
    words[1] = 32'h0000_0013;
    setup(5'h05, 5'h07, 32'h0000_0007, 1'b0, 1'b1, 32'h0000_00A5, 2);
    run_go();
    check("cycles", cyc, 8);
    check("result", {result_high, result_low},
          crc_ref(32'hA5, 32'h7, 5'h07, 5'h05, 1'b0, 0, 2));
    $display("seed test done");
  endtask

  // manual stop mid-word gives no event; a second go resumes
  task automatic test_abort();
    words[0] = 32'hDEAD_BEEF;
    words[1] = 32'h0BAD_F00D;
    setup(5'h1F, 5'h1F, 32'h04C1_1DB6, 1'b0, 1'b1, 32'h0, 2);
    @(negedge ref_clk);
    go_set = 1'b1;
    @(negedge ref_clk);
    go_set = 1'b0;
    repeat (3) @(negedge ref_clk);
    go_clear = 1'b1;
    wait_idle();
    // the word in flight still runs its sixteen shift cycles
    repeat (14) @(negedge ref_clk);
    check("events", event_count - ev0, 0);
    check("count", valid_word_count, 32'h1);
    check("result", {result_high, result_low},
          crc_ref(32'h0, 32'h04C1_1DB6, 5'h1F, 5'h1F, 1'b0, 0, 1));
    run_go();
    check("result", {result_high, result_low},
          crc_ref(32'h0, 32'h04C1_1DB6, 5'h1F, 5'h1F, 1'b0, 0, 2));
    check("events", event_count - ev0, 1);
    $display("abort test done");
  endtask

  // main sequence
  initial begin
    fail_count = 0;
    total_checks = 0;
    event_count = 0;
    reset = 1'b1;
    module_enable_bit = 1'b0;
    shift_direction_bit = 1'b0;
    interrupt_select_bit = 1'b0;
    go_set = 1'b0;
    go_clear = 1'b0;
    result_low_wr = 1'b0;
    result_high_wr = 1'b0;
    result_wdata = 16'h0000;
    data_width_field = 5'h00;
    poly_length_field = 5'h00;
    {poly_mask_high, poly_mask_low} = 32'h0;
    {data_input_high, data_input_low} = 32'h0;
    data_low_be = 2'h0;
    data_high_be = 2'h0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    test_reset();
    test_depth();
    test_msb();
    test_lsb();
    test_seed();
    test_abort();
    complete_run();
  end
endmodule
